// [psw_timer.sv]
// Shared constants, types and the phase timer of the watchdog
`timescale 1ns/1ps

package psw_pkg;
	// Clock rate
	localparam int unsigned CLOCK_HZ     = 50_000_000;
	localparam int unsigned US_PER_S     = 1_000_000;
	localparam int unsigned CYC_PER_US   = CLOCK_HZ / US_PER_S;
	// Variants
	localparam int          VAR_STD      = 0;
	localparam int          VAR_FIXED    = 1;
	localparam int          VAR_EXT      = 2;
	// Select code that turns supervision off
	localparam logic [2:0]  SEL_DISABLE  = 3'h3;
	// Alarm pulse widths in microseconds
	localparam logic [31:0] PULSE_OD_US  = 32'h000186A0;
	localparam logic [31:0] PULSE_PP_US  = 32'h000003E8;
	// Times in microseconds per select code, zero where not timed
	localparam logic [31:0] STD_US [0:7] = '{32'h3E8, 32'h2710, 32'h7530,
		32'h0, 32'h186A0, 32'hF4240, 32'h989680, 32'h3938700};
	localparam logic [31:0] FIX_DLY_US [0:7] = '{32'h3938700, 32'h3938700,
		32'h3938700, 32'h0, 32'h3938700, 32'h3938700, 32'h3938700,
		32'h3938700};
	localparam logic [31:0] FIX_TMO_US [0:7] = '{32'h3E8, 32'hBB8, 32'h2710,
		32'h0, 32'h186A0, 32'h493E0, 32'h2DC6C0, 32'h3938700};
	localparam logic [31:0] EXT_DLY_US [0:7] = '{32'hBB8, 32'hBB8,
		32'h3938700, 32'h0, 32'hC8, 32'h0, 32'h0, 32'h3938700};
	localparam logic [31:0] EXT_TMO_US [0:7] = '{32'h1E, 32'h12C, 32'hBB8,
		32'h0, 32'h2710, 32'h186A0, 32'hF4240, 32'h989680};
	// Extended-variant codes whose startup delay ends on the first edge
	localparam logic [2:0]  SEL_EDGE_A   = 3'h5;
	localparam logic [2:0]  SEL_EDGE_B   = 3'h6;

	typedef enum logic [1:0] {
		ST_DELAY = 2'h0,
		ST_WATCH = 2'h1,
		ST_ALARM = 2'h3,
		ST_OFF   = 2'h2
	} psw_state_t;

	typedef struct packed {
		logic       svc;
		logic [2:0] sel;
	} psw_pins_t;
endpackage

module psw_timer #(
	parameter int W = 32
) (
	// Clock and reset
	input  wire logic         clock,
	input  wire logic         sys_rst,
	// Control
	input  wire logic         clear,
	input  wire logic [W-1:0] limit,
	// Status
	output logic              expired,
	output logic [W-1:0]      count
);
	logic [W-1:0] count_reg;

	always_ff @(posedge clock) begin
		if (sys_rst || clear) begin
			count_reg <= '0;
		end else if (!expired) begin
			count_reg <= count_reg + {{(W-1){1'b0}}, 1'b1};
		end
	end

	// Phase ends after exactly limit cycles
	assign expired = (count_reg >= (limit - {{(W-1){1'b0}}, 1'b1}));
	assign count   = count_reg;
endmodule

// [psw_watchdog.sv]
// Pin-selectable watchdog supervisor top level
`timescale 1ns/1ps

// How it works
// - No service edge before timeout expiry pulses the alarm output.
// - Startup delay runs first, then the normal timeout supervision.
// - Alarm pulse width is fixed: 100 ms open-drain, 1 ms push-pull.
// - Alarm is active low and released or high otherwise.
// - Select pins are honoured live; a change restarts a running timeout and a delay still short of its new length, but not the alarm pulse.
// - Disable code stops supervision and the alarm never asserts.
// - Standard variant selects delay and timeout from 1 ms to 60 s; fixed variant has a 60 s delay.
// - Extended startup delay 200 us to 60 s, or until first edge.
// - Extended timeout is selectable from 30 us to 10 s.
// - Select code low-high-high disables both delay and timeout.
module psw_watchdog #(
	parameter int          VARIANT    = psw_pkg::VAR_STD,
	parameter bit          OPEN_DRAIN = 1'b1,
	parameter int unsigned CYC_PER_US = psw_pkg::CYC_PER_US
) (
	// Clock and reset
	input  wire logic       clock,
	input  wire logic       sys_rst,
	// Pins from the host
	input  wire logic       service_input,
	input  wire logic       timing_select_0,
	input  wire logic       timing_select_1,
	input  wire logic       timing_select_2,
	// Alarm pin
	output logic            alarm_output_n,
	output logic            alarm_output_oe_n,
	// Status
	output logic            supervising
);
	psw_pkg::psw_pins_t  pins_meta_reg;
	psw_pkg::psw_pins_t  pins_sync_reg;
	psw_pkg::psw_pins_t  pins_last_reg;
	psw_pkg::psw_state_t state_reg;
	psw_pkg::psw_state_t state_next;
	logic                alarm_n_reg;
	logic                oe_n_reg;
	logic                sup_reg;
	logic                svc_edge;
	logic                sel_changed;
	logic                code_off;
	logic                edge_mode;
	logic                tmr_clear;
	logic                tmr_expired;
	logic [31:0]         tmr_count;
	logic [31:0]         tmr_limit;
	logic [2:0]          code;

	function automatic logic [31:0] to_cycles(input logic [31:0] us);
		logic [63:0] p;
		p = 64'(us) * 64'(CYC_PER_US);
		return p[31:0];
	endfunction

	function automatic logic [31:0] delay_us(input logic [2:0] c);
		case (VARIANT)
			psw_pkg::VAR_FIXED: delay_us = psw_pkg::FIX_DLY_US[c];
			psw_pkg::VAR_EXT:   delay_us = psw_pkg::EXT_DLY_US[c];
			default:            delay_us = psw_pkg::STD_US[c];
		endcase
	endfunction

	function automatic logic [31:0] timeout_us(input logic [2:0] c);
		case (VARIANT)
			psw_pkg::VAR_FIXED: timeout_us = psw_pkg::FIX_TMO_US[c];
			psw_pkg::VAR_EXT:   timeout_us = psw_pkg::EXT_TMO_US[c];
			default:            timeout_us = psw_pkg::STD_US[c];
		endcase
	endfunction

	// Two-stage synchroniser, then a history stage for edges
	always_ff @(posedge clock) begin
		if (sys_rst) begin
			pins_meta_reg <= '0;
			pins_sync_reg <= '0;
			pins_last_reg <= '0;
		end else begin
			pins_meta_reg <= {service_input, timing_select_2,
				timing_select_1, timing_select_0};
			pins_sync_reg <= pins_meta_reg;
			pins_last_reg <= pins_sync_reg;
		end
	end

	assign code        = pins_sync_reg.sel;
	assign svc_edge    = pins_sync_reg.svc ^ pins_last_reg.svc;
	assign sel_changed = (pins_sync_reg.sel != pins_last_reg.sel);
	assign code_off    = (code == psw_pkg::SEL_DISABLE);
	assign edge_mode   = (VARIANT == psw_pkg::VAR_EXT) &&
		((code == psw_pkg::SEL_EDGE_A) || (code == psw_pkg::SEL_EDGE_B));

	// Next phase
	always_comb begin
		state_next = state_reg;
		if (code_off) begin
			state_next = psw_pkg::ST_OFF;
		end else begin
			case (state_reg)
				psw_pkg::ST_OFF: begin
					state_next = psw_pkg::ST_DELAY;
				end
				psw_pkg::ST_DELAY: begin
					if (edge_mode ? svc_edge : tmr_expired) begin
						state_next = psw_pkg::ST_WATCH;
					end
				end
				psw_pkg::ST_WATCH: begin
					if (tmr_expired && !svc_edge && !sel_changed) begin
						state_next = psw_pkg::ST_ALARM;
					end
				end
				psw_pkg::ST_ALARM: begin
					if (tmr_expired) begin
						state_next = psw_pkg::ST_WATCH;
					end
				end
				default: begin
					state_next = psw_pkg::ST_DELAY;
				end
			endcase
		end
	end

	// Limit of the running phase: delay and timeout from the live select code, alarm pulse fixed
	always_comb begin
		case (state_reg)
			psw_pkg::ST_DELAY: tmr_limit = to_cycles(delay_us(code));
			psw_pkg::ST_ALARM: tmr_limit = to_cycles(OPEN_DRAIN ?
				psw_pkg::PULSE_OD_US : psw_pkg::PULSE_PP_US);
			default:           tmr_limit = to_cycles(timeout_us(code));
		endcase
	end

	// Restart on phase change, service edge or new select code
	assign tmr_clear = (state_next != state_reg) ||
		((state_reg == psw_pkg::ST_WATCH) && svc_edge) ||
		((state_reg != psw_pkg::ST_ALARM) && sel_changed);

	psw_timer #(
		.W (32)
	) u_timer (
		.clock   (clock),
		.sys_rst (sys_rst),
		.clear   (tmr_clear),
		.limit   (tmr_limit),
		.expired (tmr_expired),
		.count   (tmr_count)
	);

	always_ff @(posedge clock) begin
		if (sys_rst) begin
			state_reg <= psw_pkg::ST_DELAY;
		end else begin
			state_reg <= state_next;
		end
	end

	// Alarm pin, low only during the pulse
	always_ff @(posedge clock) begin
		if (sys_rst) begin
			alarm_n_reg <= 1'b1;
			oe_n_reg    <= OPEN_DRAIN;
		end else begin
			alarm_n_reg <= (state_next != psw_pkg::ST_ALARM);
			oe_n_reg    <= OPEN_DRAIN &&
				(state_next != psw_pkg::ST_ALARM);
		end
	end

	always_ff @(posedge clock) begin
		if (sys_rst) begin
			sup_reg <= 1'b0;
		end else begin
			sup_reg <= (state_next == psw_pkg::ST_WATCH);
		end
	end

	assign alarm_output_n    = alarm_n_reg;
	assign alarm_output_oe_n = oe_n_reg;
	assign supervising       = sup_reg;

	// Checks
	logic [31:0] low_cnt_reg;

	always_ff @(posedge clock) begin
		if (sys_rst || alarm_n_reg) begin
			low_cnt_reg <= '0;
		end else begin
			low_cnt_reg <= low_cnt_reg + 32'h1;
		end
	end

	default clocking cb @(posedge clock); endclocking
	default disable iff (sys_rst);

	property p_alarm_on_timeout;
		state_reg == psw_pkg::ST_WATCH && tmr_expired && !svc_edge &&
			!sel_changed && !code_off |=> !alarm_output_n;
	endproperty
	a_alarm_on_timeout: assert property (p_alarm_on_timeout)
		else $error("timeout did not raise alarm");

	property p_pulse_width;
		$rose(alarm_output_n) && state_reg == psw_pkg::ST_WATCH |->
			low_cnt_reg == to_cycles(OPEN_DRAIN ?
			psw_pkg::PULSE_OD_US : psw_pkg::PULSE_PP_US);
	endproperty
	a_pulse_width: assert property (p_pulse_width)
		else $error("alarm pulse width wrong");

	property p_idle_high;
		state_reg != psw_pkg::ST_ALARM |-> alarm_output_n &&
			(alarm_output_oe_n == OPEN_DRAIN);
	endproperty
	a_idle_high: assert property (p_idle_high)
		else $error("alarm active outside pulse");

	property p_disable_quiet;
		code_off |=> state_reg == psw_pkg::ST_OFF ##0 alarm_output_n;
	endproperty
	a_disable_quiet: assert property (p_disable_quiet)
		else $error("disabled watchdog not quiet");

	property p_delay_then_watch;
		state_reg == psw_pkg::ST_DELAY && !edge_mode && tmr_expired &&
			!code_off |=> state_reg == psw_pkg::ST_WATCH && supervising;
	endproperty
	a_delay_then_watch: assert property (p_delay_then_watch)
		else $error("startup delay did not hand over");

	property p_select_restart;
		state_reg == psw_pkg::ST_WATCH && sel_changed && !code_off |=>
			tmr_count == 32'h0;
	endproperty
	a_select_restart: assert property (p_select_restart)
		else $error("select change did not restart timing");

	property p_edge_restart;
		state_reg == psw_pkg::ST_WATCH && svc_edge && !code_off |=>
			state_reg == psw_pkg::ST_WATCH ##0 tmr_count == 32'h0;
	endproperty
	a_edge_restart: assert property (p_edge_restart)
		else $error("service edge did not restart timeout");

	property p_first_edge_wait;
		state_reg == psw_pkg::ST_DELAY && edge_mode && !svc_edge &&
			!sel_changed |=> state_reg == psw_pkg::ST_DELAY;
	endproperty
	a_first_edge_wait: assert property (p_first_edge_wait)
		else $error("first-edge delay ended without edge");

	property p_limit_valid;
		state_reg == psw_pkg::ST_WATCH && !code_off |->
			tmr_limit != 32'h0;
	endproperty
	a_limit_valid: assert property (p_limit_valid)
		else $error("timeout limit is zero");

	c_alarm: cover property (state_reg == psw_pkg::ST_WATCH ##1
		state_reg == psw_pkg::ST_ALARM);
	c_alarm_end: cover property ($rose(alarm_output_n) &&
		state_reg == psw_pkg::ST_WATCH);
	c_serviced: cover property (state_reg == psw_pkg::ST_WATCH && svc_edge);
	c_disabled: cover property (state_reg == psw_pkg::ST_OFF);
endmodule

// [psw_host.sv]
// Host model that services the watchdog
`timescale 1ns/1ps

module psw_host #(
	parameter int PERIOD = 500
) (
	// Clock
	input  wire logic clock,
	// Control
	input  wire logic enable,
	// Service pin
	output logic      service_input
);
	int cnt;

	// Toggles the service pin at a steady rate while enabled
	initial begin
		service_input = 1'b0;
		cnt = 0;
		forever begin
			@(negedge clock);
			if (enable && cnt == PERIOD - 1) begin
				cnt = 0;
				service_input <= ~service_input;
			end else if (enable) begin
				cnt = cnt + 1;
			end
		end
	end
endmodule

// [tb_psw_watchdog.sv]
// Self-checking testbench of the watchdog
`timescale 1ns/1ps

module tb_psw_watchdog;
	localparam int D  = 1000;
	localparam int T  = 1000;
	localparam int P  = 1000;
	localparam int T1 = 10000;
	logic       clock;
	logic       sys_rst;
	logic       host_en;
	logic       svc;
	logic [2:0] sel;
	logic       alarm_n;
	logic       alarm_oe_n;
	logic       sup;
	logic       svc_x;
	logic [2:0] sel_x;
	logic       alarm_x_n;
	logic       oe_x_n;
	logic       sup_x;
	int         bad_count;
	int         compares;
	int         lows = 0;
	int         l0;
	int         n;

	psw_host #(.PERIOD(500)) host (
		.clock         (clock),
		.enable        (host_en),
		.service_input (svc)
	);

	psw_watchdog #(
		.VARIANT    (psw_pkg::VAR_STD),
		.OPEN_DRAIN (1'b0),
		.CYC_PER_US (1)
	) dut (
		.clock             (clock),
		.sys_rst           (sys_rst),
		.service_input     (svc),
		.timing_select_0   (sel[0]),
		.timing_select_1   (sel[1]),
		.timing_select_2   (sel[2]),
		.alarm_output_n    (alarm_n),
		.alarm_output_oe_n (alarm_oe_n),
		.supervising       (sup)
	);

	// Extended open-drain part waiting for its first service edge
	psw_watchdog #(
		.VARIANT    (psw_pkg::VAR_EXT),
		.OPEN_DRAIN (1'b1),
		.CYC_PER_US (1)
	) dut_ext (
		.clock             (clock),
		.sys_rst           (sys_rst),
		.service_input     (svc_x),
		.timing_select_0   (sel_x[0]),
		.timing_select_1   (sel_x[1]),
		.timing_select_2   (sel_x[2]),
		.alarm_output_n    (alarm_x_n),
		.alarm_output_oe_n (oe_x_n),
		.supervising       (sup_x)
	);

	initial begin
		clock = 1'b0;
		forever #10 clock = ~clock;
	end

	// Counts cycles with the alarm asserted
	always @(posedge clock) begin
		if (alarm_n === 1'b0) begin
			lows <= lows + 1;
		end
	end

	task automatic check(input string name, input logic [31:0] seen,
		input logic [31:0] exp);
		compares++;
		if (seen !== exp) begin
			bad_count++;
			$display("[FAIL] %s expected %0h seen %0h", name, exp, seen);
		end
	endtask

	task automatic summarize();
		$display("Counts: %0d compares, %0d mismatches", compares, bad_count);
		if (bad_count == 0 && compares > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask

	function automatic logic [31:0] rng(input int v, input int lo, input int hi);
		return (v >= lo && v <= hi) ? 32'h1 : 32'h0;
	endfunction

	// Counts falling edges until supervising or alarm reaches a level
	task automatic wait_lvl(input bit which, input logic lvl, input int lim,
		output int cnt);
		cnt = 0;
		while (((which ? sup : alarm_n) !== lvl) && cnt < lim) begin
			@(negedge clock);
			cnt++;
		end
		if ((which ? sup : alarm_n) !== lvl) begin
			bad_count++;
			$display("[FAIL] wait level %0b expected reached seen timeout", lvl);
			summarize();
		end
	endtask

	// Stops the host just after its next service edge
	task automatic stop_host();
		logic old;
		int   cnt;
		old = svc;
		cnt = 0;
		while (svc === old && cnt < 600) begin
			@(negedge clock);
			cnt++;
		end
		host_en = 1'b0;
		if (svc === old) begin
			bad_count++;
			$display("[FAIL] host_edge expected toggle seen none");
			summarize();
		end
	endtask

	initial begin
		sys_rst = 1'b1;
		host_en = 1'b0;
		sel = 3'h0;
		svc_x = 1'b0;
		sel_x = 3'h5;
		bad_count = 0;
		compares = 0;
		repeat (5) @(negedge clock);
		check("alarm_in_reset", alarm_n, 1'b1);
		check("sup_in_reset", sup, 1'b0);
		sys_rst = 1'b0;
		wait_lvl(1'b1, 1'b1, D + 50, n);
		check("startup_len", rng(n, D, D + 4), 32'h1);
		check("first_edge_hold", sup_x, 1'b0);
		check("od_released", oe_x_n, 1'b1);
		svc_x = 1'b1;
		repeat (4) @(negedge clock);
		check("first_edge_go", sup_x, 1'b1);
		check("od_alarm_idle", alarm_x_n, 1'b1);
		$display("Test startup done");
		l0 = lows;
		host_en = 1'b1;
		repeat (3000) @(negedge clock);
		check("serviced_alarms", lows - l0, 32'h0);
		stop_host();
		wait_lvl(1'b0, 1'b0, T + 50, n);
		check("timeout_len", rng(n, T, T + 8), 32'h1);
		check("drive_enable", alarm_oe_n, 1'b0);
		wait_lvl(1'b0, 1'b1, P + 50, n);
		check("pulse_width", n, P);
		check("sup_after_pulse", sup, 1'b1);
		$display("Test timeout done");
		sel = 3'h1;
		host_en = 1'b1;
		repeat (2000) @(negedge clock);
		stop_host();
		repeat (T + 100) @(negedge clock);
		check("long_hold", alarm_n, 1'b1);
		wait_lvl(1'b0, 1'b0, T1, n);
		check("long_len", rng(n + T + 100, T1, T1 + 8), 32'h1);
		wait_lvl(1'b0, 1'b1, P + 50, n);
		$display("Test live select done");
		sel = 3'h3;
		repeat (10) @(negedge clock);
		l0 = lows;
		check("sup_disabled", sup, 1'b0);
		repeat (12000) @(negedge clock);
		check("disabled_alarms", lows - l0, 32'h0);
		sel = 3'h0;
		wait_lvl(1'b1, 1'b1, D + 50, n);
		check("restart_delay", rng(n, D, D + 6), 32'h1);
		$display("Test disable done");
		summarize();
	end
endmodule
